// ### rtl/uabd_pkg.sv
// Package with constants for the auto-baud detector
package uabd_pkg;
   localparam int DIV_WIDTH = 16;
   localparam int PRE_WIDTH = 9;
   // Prescale terminal counts for the measurement clock enable (divide minus one)
   localparam logic [8:0] ABD_DIV_SLOW = 9'h1ff; // Fosc/512
   localparam logic [8:0] ABD_DIV_MID = 9'h07f; // Fosc/128
   localparam logic [8:0] ABD_DIV_FAST = 9'h01f; // Fosc/32
   localparam logic [15:0] DIVISOR_START = 16'h0001;
   localparam logic [15:0] DIVISOR_RESET = 16'h0000;
   localparam logic [2:0] RISE_LAST = 3'h5;
   // Register offsets of the plain register port
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_DIV_LOW = 4'h1;
   localparam logic [3:0] ADDR_DIV_HIGH = 4'h2;
   localparam logic [3:0] ADDR_RX_DATA = 4'h3;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
   // Control register bits
   localparam int CTL_AUTOBAUD_ENABLE = 0;
   localparam int CTL_WAKE_ON_BREAK = 1;
   localparam int CTL_WIDE_DIVISOR = 2;
   localparam int CTL_HIGH_SPEED = 3;
   localparam int CTL_RECEIVER_IDLE = 4;
   // Interrupt status bits
   localparam int IRQ_RECEIVE = 0;
   localparam int IRQ_DONE = 1;
   localparam int IRQ_BITS = 2;
   typedef enum logic [2:0] {
      ST_IDLE, ST_BREAK, ST_BREAK_END, ST_START, ST_COUNT
   } uabd_state_type;
endpackage

// ### rtl/uabd_rate_div.sv
// Measurement clock enable divider selected by the rate selects
`timescale 1ns/1ps
`default_nettype none
module uabd_rate_div (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CLEAR,
   input wire logic WIDE_SEL,
   input wire logic HIGH_SEL,
   output logic TICK
);
   typedef struct packed {
      logic [uabd_pkg::PRE_WIDTH-1:0] count;
   } uabd_div_state_type;
   uabd_div_state_type state, next_state;
   logic [uabd_pkg::PRE_WIDTH-1:0] limit;
   // Terminal count from the two selects
   always_comb begin
      unique case ({WIDE_SEL, HIGH_SEL})
         2'b00: limit = uabd_pkg::ABD_DIV_SLOW;
         2'b11: limit = uabd_pkg::ABD_DIV_FAST;
         default: limit = uabd_pkg::ABD_DIV_MID;
      endcase
      next_state = state;
      TICK = (state.count >= limit);
      if (CLEAR || TICK) begin
         next_state.count = '0;
      end else begin
         next_state.count = state.count + 1'b1;
      end
   end
   // State register
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
endmodule
`default_nettype wire

// ### rtl/uabd_autobaud.sv
// Auto-baud measurement logic of a serial receiver with register port
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module uabd_autobaud (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic RX,
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RX_BYTE,
   input wire logic RX_BYTE_VALID,
   output logic [7:0] RDATA,
   output logic RECEIVER_HOLD,
   output logic [15:0] DIVISOR,
   output logic IRQ
);
   typedef struct packed {
      uabd_pkg::uabd_state_type fsm;
      logic rx_prev;
      logic [2:0] rises;
      logic [15:0] divisor;
      logic autobaud_enable;
      logic wake_on_break_enable;
      logic wide_divisor_select;
      logic high_speed_select;
      logic [7:0] receive_data_reg;
      logic [uabd_pkg::IRQ_BITS-1:0] irq_status;
      logic [uabd_pkg::IRQ_BITS-1:0] irq_mask;
      logic [7:0] rdata;
   } uabd_top_state_type;
   uabd_top_state_type state, next_state;
   logic tick;
   logic div_clear;
   logic rise;
   logic wr_ctl;
   logic [uabd_pkg::IRQ_BITS-1:0] irq_set;
   // Measurement rate enable; restarted whenever a count phase begins
   uabd_rate_div u_div (
      .CLK(CLK),
      .RST_N(RST_N),
      .CLEAR(div_clear),
      .WIDE_SEL(state.wide_divisor_select),
      .HIGH_SEL(state.high_speed_select),
      .TICK(tick)
   );
   // Next state of the whole block
   always_comb begin
      next_state = state;
      irq_set = '0;
      rise = RX && !state.rx_prev;
      div_clear = (state.fsm != uabd_pkg::ST_COUNT);
      wr_ctl = WR && (ADDR == uabd_pkg::ADDR_CONTROL);
      next_state.rx_prev = RX;
      next_state.rdata = 8'h00;
      // Register writes
      if (wr_ctl) begin
         next_state.autobaud_enable = WDATA[uabd_pkg::CTL_AUTOBAUD_ENABLE];
         next_state.wake_on_break_enable = WDATA[uabd_pkg::CTL_WAKE_ON_BREAK];
         next_state.wide_divisor_select = WDATA[uabd_pkg::CTL_WIDE_DIVISOR];
         next_state.high_speed_select = WDATA[uabd_pkg::CTL_HIGH_SPEED];
      end
      if (WR && ADDR == uabd_pkg::ADDR_DIV_LOW && !state.autobaud_enable) begin
         next_state.divisor[7:0] = WDATA;
      end
      if (WR && ADDR == uabd_pkg::ADDR_DIV_HIGH && !state.autobaud_enable) begin
         next_state.divisor[15:8] = WDATA;
      end
      if (WR && ADDR == uabd_pkg::ADDR_IRQ_MASK) begin
         next_state.irq_mask = WDATA[uabd_pkg::IRQ_BITS-1:0];
      end
      if (WR && ADDR == uabd_pkg::ADDR_IRQ_STATUS) begin
         next_state.irq_status = state.irq_status & ~WDATA[uabd_pkg::IRQ_BITS-1:0];
      end
      // Register reads, data in the following cycle
      if (RD) begin
         unique case (ADDR)
            uabd_pkg::ADDR_CONTROL: next_state.rdata = {3'h0, !state.autobaud_enable,
               state.high_speed_select, state.wide_divisor_select,
               state.wake_on_break_enable, state.autobaud_enable};
            uabd_pkg::ADDR_DIV_LOW: next_state.rdata = state.divisor[7:0];
            uabd_pkg::ADDR_DIV_HIGH: next_state.rdata = state.divisor[15:8];
            uabd_pkg::ADDR_RX_DATA: next_state.rdata = state.receive_data_reg;
            uabd_pkg::ADDR_IRQ_STATUS: next_state.rdata = {6'h00, state.irq_status};
            uabd_pkg::ADDR_IRQ_MASK: next_state.rdata = {6'h00, state.irq_mask};
            default: next_state.rdata = 8'h00;
         endcase
      end
      // Reading the data register clears the receive flag
      if (RD && ADDR == uabd_pkg::ADDR_RX_DATA) begin
         next_state.irq_status[uabd_pkg::IRQ_RECEIVE] = 1'b0;
      end
      // Normal reception only when not calibrating
      if (RX_BYTE_VALID && !state.autobaud_enable) begin
         next_state.receive_data_reg = RX_BYTE;
         irq_set[uabd_pkg::IRQ_RECEIVE] = 1'b1;
      end
      // Measurement sequencer
      unique case (state.fsm)
         uabd_pkg::ST_IDLE: begin
            if (wr_ctl && WDATA[uabd_pkg::CTL_AUTOBAUD_ENABLE]) begin
               next_state.divisor = uabd_pkg::DIVISOR_START;
               next_state.rises = '0;
               if (WDATA[uabd_pkg::CTL_WAKE_ON_BREAK]) begin
                  next_state.fsm = uabd_pkg::ST_BREAK;
               end else begin
                  next_state.fsm = uabd_pkg::ST_START;
               end
            end
         end
         uabd_pkg::ST_BREAK: begin
            // Wait for break low to begin
            if (!RX) begin
               next_state.fsm = uabd_pkg::ST_BREAK_END;
            end
         end
         uabd_pkg::ST_BREAK_END: begin
            // Break ends on its rising edge; sync follows
            if (rise) begin
               next_state.fsm = uabd_pkg::ST_START;
            end
         end
         uabd_pkg::ST_START: begin
            // First rising edge after the start bit opens the count
            if (rise) begin
               next_state.rises = 3'h1;
               next_state.fsm = uabd_pkg::ST_COUNT;
            end
         end
         uabd_pkg::ST_COUNT: begin
            if (tick) begin
               next_state.divisor = state.divisor + 1'b1;
            end
            if (rise) begin
               next_state.rises = state.rises + 1'b1;
               if (state.rises + 1'b1 == uabd_pkg::RISE_LAST) begin
                  next_state.divisor = state.divisor;
                  next_state.fsm = uabd_pkg::ST_IDLE;
                  next_state.autobaud_enable = 1'b0;
                  irq_set = '1;
               end
            end
         end
      endcase
      // Software abort by clearing the enable
      if (wr_ctl && !WDATA[uabd_pkg::CTL_AUTOBAUD_ENABLE]) begin
         next_state.fsm = uabd_pkg::ST_IDLE;
      end
      // Hardware set wins over software clear
      next_state.irq_status = next_state.irq_status | irq_set;
   end
   // Outputs
   assign RDATA = state.rdata;
   assign RECEIVER_HOLD = state.autobaud_enable;
   assign DIVISOR = state.divisor;
   assign IRQ = |(state.irq_status & state.irq_mask);
   // State register
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state <= '{fsm: uabd_pkg::ST_IDLE, rx_prev: 1'b1,
            divisor: uabd_pkg::DIVISOR_RESET, default: '0};
      end else begin
         state <= next_state;
      end
   end
endmodule
`default_nettype wire

// ### tb/uabd_autobaud_asserts.sv
// Port assertions for the auto-baud detector
`timescale 1ns/1ps
`default_nettype none
module uabd_autobaud_asserts (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic RX,
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RX_BYTE,
   input wire logic RX_BYTE_VALID,
   input wire logic [7:0] RDATA,
   input wire logic RECEIVER_HOLD,
   input wire logic [15:0] DIVISOR,
   input wire logic IRQ
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Arming, counting, freezing and completion
   property p_arm; WR && ADDR == 4'h0 && WDATA[0] |=> RECEIVER_HOLD; endproperty
   a_arm: assert property (p_arm) else $error("arm");
   property p_init; $rose(RECEIVER_HOLD) |-> DIVISOR == 16'h0001; endproperty
   a_init: assert property (p_init) else $error("init");
   property p_step; $changed(DIVISOR) && $past(RECEIVER_HOLD)
      |-> DIVISOR == $past(DIVISOR) + 16'h0001; endproperty
   a_step: assert property (p_step) else $error("step");
   property p_idle; !RECEIVER_HOLD && !$past(RECEIVER_HOLD) && !$past(WR)
      |-> $stable(DIVISOR); endproperty
   a_idle: assert property (p_idle) else $error("idle");
   property p_end; $fell(RECEIVER_HOLD) && !$past(WR) |-> RX && $past(RX); endproperty
   a_end: assert property (p_end) else $error("end");
   // Register views and interrupt
   property p_ctl; $past(RD) && $past(ADDR) == 4'h0
      |-> RDATA[0] == $past(RECEIVER_HOLD) && RDATA[4] != RDATA[0]; endproperty
   a_ctl: assert property (p_ctl) else $error("ctl");
   property p_low; $past(RD) && $past(ADDR) == 4'h1
      |-> {8'h00, RDATA} == ($past(DIVISOR) & 16'h00ff); endproperty
   a_low: assert property (p_low) else $error("low");
   property p_irq; $rose(IRQ) |-> !RECEIVER_HOLD || $past(WR) || $past(WR, 2); endproperty
   a_irq: assert property (p_irq) else $error("irq");
   c_done: cover property ($fell(RECEIVER_HOLD) && !$past(WR));
   c_irq: cover property ($rose(IRQ));
   c_rx: cover property ($past(RD) && $past(ADDR) == 4'h3);
endmodule
bind uabd_autobaud uabd_autobaud_asserts i_chk (.CLK(CLK), .RST_N(RST_N), .RX(RX),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RX_BYTE(RX_BYTE),
   .RX_BYTE_VALID(RX_BYTE_VALID), .RDATA(RDATA), .RECEIVER_HOLD(RECEIVER_HOLD),
   .DIVISOR(DIVISOR), .IRQ(IRQ));
`default_nettype wire

// ### tb/uabd_sync_tx.sv
// Remote transmitter model sending the sync character
`timescale 1ns/1ps
`default_nettype none
module uabd_sync_tx (
   input wire logic clk,
   input wire logic go,
   input wire logic brk,
   input wire logic [15:0] bit_clks,
   output logic line = 1'b1
);
   localparam logic [9:0] FRAME = 10'h2aa; // Start, 55h LSB first, stop
   // Optional break, then one frame; line idles high
   always @(posedge clk) begin
      if (go) begin
         if (brk) begin
            line <= 1'b0;
            repeat (12 * bit_clks) @(posedge clk);
            line <= 1'b1;
            repeat (bit_clks) @(posedge clk);
         end
         for (int i = 0; i < 10; i++) begin
            line <= FRAME[i];
            repeat (bit_clks) @(posedge clk);
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/uabd_autobaud_tb.sv
// Self-checking testbench for the auto-baud detector
`timescale 1ns/1ps
`default_nettype none
module uabd_autobaud_tb;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0, brk = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic [15:0] bit_clks = 16'h0021;
   logic [7:0] rx_byte = 8'h00;
   logic rx_byte_valid = 1'b0;
   logic rx, hold, irq;
   logic [7:0] rdata;
   logic [15:0] divisor;
   int checks = 0;
   int fail_count = 0;
   uabd_sync_tx i_tx (.clk(clk), .go(go), .brk(brk), .bit_clks(bit_clks), .line(rx));
   uabd_autobaud i_dut (.CLK(clk), .RST_N(rst_n), .RX(rx), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RX_BYTE(rx_byte), .RX_BYTE_VALID(rx_byte_valid), .RDATA(rdata),
      .RECEIVER_HOLD(hold), .DIVISOR(divisor), .IRQ(irq));
   // Free-running system clock
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic put(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic get(input logic [3:0] a, input logic [7:0] e, input logic c);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      if (c) chk({8'h00, rdata}, {8'h00, e});
   endtask
   task automatic results;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Normal reception outside calibration: byte stored, flag raised, data read clears it
   task automatic t_rx;
      put(4'h5, 8'h01);
      rx_byte <= 8'h3c;
      rx_byte_valid <= 1'b1;
      @(posedge clk);
      rx_byte_valid <= 1'b0;
      #1;
      chk({15'h0000, irq}, 16'h0001);
      get(4'h4, 8'h01, 1'b1);
      get(4'h3, 8'h3c, 1'b1);
      chk({15'h0000, irq}, 16'h0000);
   endtask
   // One calibration: arm, refused divisor write, sync frame, readback, flag clear
   task automatic t_cal(input logic [7:0] ctl, input logic [15:0] b, input logic k);
      put(4'h5, 8'h01);
      put(4'h0, ctl);
      put(4'h1, 8'haa);
      #1;
      chk({15'h0000, hold}, 16'h0001);
      chk(divisor, 16'h0001);
      bit_clks <= b;
      brk <= k;
      go <= 1'b1;
      rx_byte <= 8'hc3;
      rx_byte_valid <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      rx_byte_valid <= 1'b0;
      for (int n = 0; n < 20000 && hold; n++) begin
         @(posedge clk);
         #1;
      end
      chk({15'h0000, hold}, 16'h0000);
      if (hold) results();
      chk(divisor - 16'h0001, 16'h0008);
      get(4'h0, (ctl & 8'h0e) | 8'h10, 1'b1);
      chk({15'h0000, irq}, 16'h0001);
      get(4'h2, 8'h00, 1'b1);
      get(4'h4, 8'h03, 1'b1);
      get(4'h3, 8'h3c, 1'b1);
      get(4'h4, 8'h02, 1'b1);
      chk({15'h0000, irq}, 16'h0000);
      put(4'h4, 8'h03);
      // Let the stop bit run out so the transmitter sees the next start request
      repeat (bit_clks) @(posedge clk);
   endtask
   // Reset, idle state, then every rate select and a break-led frame
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk(divisor, 16'h0000);
      get(4'h0, 8'h10, 1'b1);
      get(4'hf, 8'h00, 1'b1);
      t_rx();
      t_cal(8'h01, 16'h0210, 1'b0);
      t_cal(8'h09, 16'h0084, 1'b0);
      t_cal(8'h05, 16'h0084, 1'b0);
      t_cal(8'h0d, 16'h0021, 1'b0);
      t_cal(8'h0f, 16'h0021, 1'b1);
      results();
   end
endmodule
`default_nettype wire
